// ===== core/ecr_map.svh
// Constants of the emulated register file: entry indices, field positions, reset values and bus offsets.
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH

`define ECR_FLAGS 4'h0
`define ECR_INSTR 4'h1
`define ECR_XL 4'h2
`define ECR_XH 4'h3
`define ECR_AL 4'h4
`define ECR_AH 4'h5
`define ECR_BL 4'h6
`define ECR_BH 4'h7
`define ECR_OAL 4'h8
`define ECR_OAH 4'h9
`define ECR_PL 4'ha
`define ECR_PH 4'hb
`define ECR_CTL 4'hf
`define ECR_VISIBLE 16'h8cfc
`define ECR_ENTRY_RST 8'h00
`define ECR_PC_TOP_BIT 7
`define ECR_W_LSB 2
`define ECR_W_MSB 3
`define ECR_OVF_BIT 0
`define ECR_OPC_VAR_BIT 3
`define ECR_FIXED_LEN 3'h2
`define ECR_BUS_FILE_BIT 4
`define ECR_BUS_STATUS 5'h10
`define ECR_BUS_MASK 5'h11
`define ECR_BUS_INFO 5'h12
`define ECR_EV_OVF 0
`define ECR_EV_WLEN 1
`define ECR_EV_REFUSE 2
`define ECR_EV_CMPEQ 3
`define ECR_EV_RST 4'h0

`endif

// ===== core/ecr_pkg.sv
// Types shared by the emulated register file and its users.
package ecr_pkg;
	typedef enum logic [3:0] {
		ECR_CMD_NOP = 4'b0000,
		ECR_CMD_SHL_A = 4'b0001,
		ECR_CMD_SHR_A = 4'b0010,
		ECR_CMD_SHL_B = 4'b0011,
		ECR_CMD_SHR_B = 4'b0100,
		ECR_CMD_SHL_AB = 4'b0101,
		ECR_CMD_SHR_AB = 4'b0110,
		ECR_CMD_INC_X = 4'b0111,
		ECR_CMD_INC_P = 4'b1000,
		ECR_CMD_CMP_XA = 4'b1001,
		ECR_CMD_SET_OVF = 4'b1010,
		ECR_CMD_CLR_OVF = 4'b1011,
		ECR_CMD_JMP_OVF = 4'b1100,
		ECR_CMD_LOAD_W = 4'b1101
	} ecr_cmd_t;
endpackage

// ===== core/ecr_file.sv
// Register file of the emulated byte-oriented minicomputer with its microcycle and software ports.
//
// Function
// [RQ1] Primary accumulator is 16 bits in entries 4 and 5, the main working register.
// [RQ2] Primary accumulator holds upper part of 24/32-bit data, all of 8/16-bit data.
// [RQ3] Shifts act on either accumulator alone or on both joined.
// [RQ4] Auxiliary accumulator is 16 bits in entries 6 and 7, low half of long data.
// [RQ5] Index is 16 bits in entries 2 and 3; memory transfer, increment, compare.
// [RQ6] Program counter is 15 bits in entries A and B, next instruction address.
// [RQ7] Two-bit word length loaded only by control instruction selects variable operand length; microcycle and software writes to entry F also load it.
// [RQ8] Word length starts at bit 2 of entry F, overflow in the low bits.
// [RQ9] Overflow is set by arithmetic overflow, control instruction or compare.
// [RQ10] Overflow is cleared by control instruction or by jump testing overflow.
// [RQ11] Entries 8 and 9 hold the computed operand address.
// [RQ12] Entries C, D and E are hidden scratch storage for the microprogram.
// [RQ13] Entry 0 holds condition flags, entry 1 the fetched instruction byte.
// [RQ14] Nine entries are visible; the other seven are reachable only at micro level.
// [RQ15] Load, store and arithmetic use one to four byte operands set by word length.
// [RQ16] Variable length applies only when opcode bit 3 asks; length comes from entry F.
// [RQ17] All entries are written on the one clock, readable in the next cycle.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "ecr_map.svh"

module ecr_file (
	input logic clk,
	input logic rst,
	input logic ce,
	input ecr_pkg::ecr_cmd_t mc_cmd,
	input logic [7:0] mc_arg,
	input logic arith_ovf,
	input logic [7:0] opcode,
	input logic mc_priv,
	input logic mc_wr,
	input logic [3:0] mc_waddr,
	input logic [7:0] mc_wdata,
	input logic [3:0] mc_raddr_a,
	input logic [3:0] mc_raddr_b,
	output logic [7:0] mc_rdata_a,
	output logic [7:0] mc_rdata_b,
	output logic [15:0] acc_a,
	output logic [15:0] acc_b,
	output logic [15:0] index_x,
	output logic [14:0] prog_cnt,
	output logic [15:0] oper_addr,
	output logic [7:0] instr_byte,
	output logic [7:0] cond_flags,
	output logic ovf,
	output logic [1:0] word_len,
	output logic var_len,
	output logic [2:0] op_len,
	output logic shift_out,
	output logic cmp_eq,
	input logic [4:0] bus_addr,
	input logic [31:0] bus_wdata,
	input logic bus_wr,
	input logic bus_rd,
	output logic [31:0] bus_rdata,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage and helpers.

	logic [7:0] file [16];
	logic [7:0] next_file [16];
	logic [3:0] status;
	logic [3:0] mask;
	logic next_shift;
	logic [3:0] events;
	logic [15:0] pc_pair;

	// Pairs are held low byte in the lower entry, high byte in the entry above it.
	function automatic logic [15:0] pair(input logic [3:0] lo);
		logic [3:0] hi;
		hi = lo + 4'h1;
		pair = {file[hi], file[lo]};
	endfunction

	// Emulated instructions only see the architectural entries.
	function automatic logic reachable(input logic [3:0] idx, input logic priv);
		logic [15:0] vis;
		vis = `ECR_VISIBLE;
		reachable = priv | vis[idx]; // RQ14
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Architectural views.

	assign acc_a = pair(`ECR_AL); // RQ1
	assign acc_b = pair(`ECR_BL); // RQ4
	assign index_x = pair(`ECR_XL); // RQ5
	// The top bit of the pair is held at zero, so the 15-bit view loses nothing.
	assign pc_pair = pair(`ECR_PL);
	assign prog_cnt = pc_pair[14:0]; // RQ6
	assign oper_addr = pair(`ECR_OAL); // RQ11
	assign instr_byte = file[`ECR_INSTR]; // RQ13
	assign cond_flags = file[`ECR_FLAGS]; // RQ13
	assign ovf = file[`ECR_CTL][`ECR_OVF_BIT]; // RQ8
	assign word_len = file[`ECR_CTL][`ECR_W_MSB:`ECR_W_LSB]; // RQ8

	// Without the opcode request, operands keep the fixed word of two bytes.
	assign var_len = opcode[`ECR_OPC_VAR_BIT]; // RQ16
	assign op_len = var_len ? ({1'b0, word_len} + 3'h1) : `ECR_FIXED_LEN; // RQ15

	// Hidden entries read as zero to emulated-level accesses.
	assign mc_rdata_a = reachable(mc_raddr_a, mc_priv) ? file[mc_raddr_a] : `ECR_ENTRY_RST; // RQ12
	assign mc_rdata_b = reachable(mc_raddr_b, mc_priv) ? file[mc_raddr_b] : `ECR_ENTRY_RST; // RQ12

	////////////////////////////////////////////////////////////////////////////////
	// Next state of the file.

	always_comb
	begin
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] x;
		logic [15:0] p;
		logic ovf_set;
		logic ovf_clr;
		logic keep_ovf;
		a = pair(`ECR_AL);
		b = pair(`ECR_BL);
		x = pair(`ECR_XL);
		p = pair(`ECR_PL) + 16'h0001;
		ovf_set = arith_ovf; // RQ9
		ovf_clr = 1'b0;
		keep_ovf = 1'b0;
		next_shift = shift_out;
		events = `ECR_EV_RST;
		for (int i = 0; i < 16; i++)
			next_file[i] = file[i];
		case (mc_cmd)
			ecr_pkg::ECR_CMD_SHL_A:
			begin
				{next_file[`ECR_AH], next_file[`ECR_AL]} = {a[14:0], mc_arg[0]}; // RQ3
				next_shift = a[15];
			end
			ecr_pkg::ECR_CMD_SHR_A:
			begin
				{next_file[`ECR_AH], next_file[`ECR_AL]} = {mc_arg[0], a[15:1]}; // RQ3
				next_shift = a[0];
			end
			ecr_pkg::ECR_CMD_SHL_B:
			begin
				{next_file[`ECR_BH], next_file[`ECR_BL]} = {b[14:0], mc_arg[0]}; // RQ3
				next_shift = b[15];
			end
			ecr_pkg::ECR_CMD_SHR_B:
			begin
				{next_file[`ECR_BH], next_file[`ECR_BL]} = {mc_arg[0], b[15:1]}; // RQ3
				next_shift = b[0];
			end
			ecr_pkg::ECR_CMD_SHL_AB:
			begin
				// The primary accumulator is the upper half of the joined quantity.
				{next_file[`ECR_AH], next_file[`ECR_AL], next_file[`ECR_BH], next_file[`ECR_BL]} =
					{a[14:0], b, mc_arg[0]}; // RQ2 RQ3
				next_shift = a[15];
			end
			ecr_pkg::ECR_CMD_SHR_AB:
			begin
				{next_file[`ECR_AH], next_file[`ECR_AL], next_file[`ECR_BH], next_file[`ECR_BL]} =
					{mc_arg[0], a, b[15:1]}; // RQ2 RQ3
				next_shift = b[0];
			end
			ecr_pkg::ECR_CMD_INC_X:
				{next_file[`ECR_XH], next_file[`ECR_XL]} = x + 16'h0001; // RQ5
			ecr_pkg::ECR_CMD_INC_P:
				{next_file[`ECR_PH], next_file[`ECR_PL]} = p; // RQ6
			ecr_pkg::ECR_CMD_CMP_XA:
			begin
				// Compare marks a mismatch in the overflow flag.
				ovf_set = ovf_set | (x != a); // RQ5 RQ9
				events[`ECR_EV_CMPEQ] = (x == a);
			end
			ecr_pkg::ECR_CMD_SET_OVF:
				ovf_set = 1'b1; // RQ9
			ecr_pkg::ECR_CMD_CLR_OVF:
				ovf_clr = 1'b1; // RQ10
			ecr_pkg::ECR_CMD_JMP_OVF:
				ovf_clr = 1'b1; // RQ10
			ecr_pkg::ECR_CMD_LOAD_W:
			begin
				next_file[`ECR_CTL][`ECR_W_MSB:`ECR_W_LSB] = mc_arg[1:0]; // RQ7
				events[`ECR_EV_WLEN] = 1'b1;
			end
			default:
				next_shift = shift_out;
		endcase
		// Software writes lose to the microcycle port on the same entry.
		if (bus_wr && !bus_addr[`ECR_BUS_FILE_BIT])
			next_file[bus_addr[3:0]] = bus_wdata[7:0];
		if (mc_wr && reachable(mc_waddr, mc_priv))
			next_file[mc_waddr] = mc_wdata; // RQ14
		events[`ECR_EV_REFUSE] = mc_wr && !reachable(mc_waddr, mc_priv); // RQ12
		// An overflow arriving in the cycle of its clear survives it.
		keep_ovf = next_file[`ECR_CTL][`ECR_OVF_BIT] & ~ovf_clr;
		next_file[`ECR_CTL][`ECR_OVF_BIT] = ovf_set | keep_ovf; // RQ9 RQ10
		events[`ECR_EV_OVF] = ovf_set;
		next_file[`ECR_PH][`ECR_PC_TOP_BIT] = 1'b0; // RQ6
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 16; i++)
				file[i] <= `ECR_ENTRY_RST;
		end
		else if (ce)
		begin
			for (int i = 0; i < 16; i++)
				file[i] <= next_file[i]; // RQ17
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			shift_out <= 1'b0;
			cmp_eq <= 1'b0;
		end
		else if (ce)
		begin
			shift_out <= next_shift;
			if (mc_cmd == ecr_pkg::ECR_CMD_CMP_XA)
				cmp_eq <= events[`ECR_EV_CMPEQ]; // RQ5
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software port and interrupt.

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status <= `ECR_EV_RST;
			mask <= `ECR_EV_RST;
		end
		else if (ce)
		begin
			if (bus_wr && bus_addr == `ECR_BUS_STATUS)
				status <= (status & ~bus_wdata[3:0]) | events;
			else
				status <= status | events;
			if (bus_wr && bus_addr == `ECR_BUS_MASK)
				mask <= bus_wdata[3:0];
		end
	end

	assign irq = |(status & mask);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bus_rdata <= 32'h0000_0000;
		else if (ce)
		begin
			bus_rdata <= 32'h0000_0000;
			if (bus_rd)
			begin
				if (!bus_addr[`ECR_BUS_FILE_BIT])
					bus_rdata <= {24'h00_0000, file[bus_addr[3:0]]};
				else if (bus_addr == `ECR_BUS_STATUS)
					bus_rdata <= {28'h000_0000, status};
				else if (bus_addr == `ECR_BUS_MASK)
					bus_rdata <= {28'h000_0000, mask};
				else if (bus_addr == `ECR_BUS_INFO)
					bus_rdata <= {24'h00_0000, cmp_eq, shift_out, var_len, op_len, word_len};
			end
		end
	end

endmodule

// ===== dv/ecr_seq_model.sv
// Sequencer model that takes the overflow jump decision.
`timescale 1ns/1ps
module ecr_seq_model (
	input logic clk,
	input logic rst,
	input logic ce,
	input ecr_pkg::ecr_cmd_t mc_cmd,
	input logic ovf,
	output logic jump_taken
);
	// The jump tests the flag as it stood before the edge that clears it.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			jump_taken <= 1'b0;
		else if (ce && mc_cmd == ecr_pkg::ECR_CMD_JMP_OVF)
			jump_taken <= ovf;
	end
endmodule

// ===== dv/ecr_monitor.sv
// Assertion checker for the emulated register file.
`timescale 1ns/1ps
module ecr_monitor (
	input logic clk,
	input logic rst,
	input logic ce,
	input ecr_pkg::ecr_cmd_t mc_cmd,
	input logic [7:0] mc_arg,
	input logic arith_ovf,
	input logic [7:0] opcode,
	input logic mc_priv,
	input logic mc_wr,
	input logic bus_wr,
	input logic [3:0] mc_raddr_a,
	input logic [7:0] mc_rdata_a,
	input logic [15:0] acc_a,
	input logic [15:0] index_x,
	input logic [14:0] prog_cnt,
	input logic ovf,
	input logic [1:0] word_len,
	input logic [2:0] op_len
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Writes outrank shift, increment and length commands, so only cycles without them show a command alone.
	wire calm = ce && !mc_wr && !bus_wr && !arith_ovf;
	sequence s_shl;
		calm && mc_cmd == ecr_pkg::ECR_CMD_SHL_A;
	endsequence
	a_shl_fill: assert property (s_shl |=> acc_a == {$past(acc_a[14:0]), $past(mc_arg[0])})
		else $error("shift left of acc_a wrong");
	a_inc_idx: assert property (calm && mc_cmd == ecr_pkg::ECR_CMD_INC_X |=> index_x == $past(index_x) + 16'h1)
		else $error("index increment wrong");
	a_inc_pc: assert property (calm && mc_cmd == ecr_pkg::ECR_CMD_INC_P |=> prog_cnt == $past(prog_cnt) + 15'h1)
		else $error("program counter increment wrong");
	a_ovf_set: assert property (ce && arith_ovf |=> ovf)
		else $error("overflow not set");
	a_cmp_ovf: assert property (calm && mc_cmd == ecr_pkg::ECR_CMD_CMP_XA && index_x != acc_a |=> ovf)
		else $error("compare mismatch left overflow clear");
	a_ovf_clr: assert property (calm && mc_cmd == ecr_pkg::ECR_CMD_CLR_OVF |=> !ovf)
		else $error("overflow not cleared");
	a_wlen_load: assert property (calm && mc_cmd == ecr_pkg::ECR_CMD_LOAD_W |=> word_len == $past(mc_arg[1:0]))
		else $error("word length not loaded");
	a_wlen_hold: assert property (mc_cmd != ecr_pkg::ECR_CMD_LOAD_W && !mc_wr && !bus_wr |=> $stable(word_len))
		else $error("word length changed without load");
	a_op_len: assert property (op_len == (opcode[3] ? {1'b0, word_len} + 3'h1 : 3'h2))
		else $error("operand length wrong");
	a_hide_rd: assert property (!mc_priv && mc_raddr_a == 4'hc |-> mc_rdata_a == 8'h00)
		else $error("hidden entry visible");
endmodule

bind ecr_file ecr_monitor ecr_monitor_i (.clk, .rst, .ce, .mc_cmd, .mc_arg, .arith_ovf, .opcode, .mc_priv, .mc_wr,
	.bus_wr, .mc_raddr_a, .mc_rdata_a, .acc_a, .index_x, .prog_cnt, .ovf, .word_len, .op_len);

// ===== dv/tb_top.sv
// Self-checking bench for the emulated register file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, arith_ovf = 1'b0, mc_priv = 1'b0, mc_wr = 1'b0;
	logic bus_wr = 1'b0, bus_rd = 1'b0, ovf, var_len, shift_out, cmp_eq, irq, jump_taken;
	ecr_pkg::ecr_cmd_t mc_cmd = ecr_pkg::ECR_CMD_NOP;
	logic [7:0] mc_arg = 8'h00, opcode = 8'h00, mc_wdata = 8'h00, mc_rdata_a, mc_rdata_b, instr_byte, cond_flags;
	logic [3:0] mc_waddr = 4'h0, mc_raddr_a = 4'h0, mc_raddr_b = 4'h0;
	logic [15:0] acc_a, acc_b, index_x, oper_addr;
	logic [14:0] prog_cnt;
	logic [1:0] word_len;
	logic [2:0] op_len;
	logic [4:0] bus_addr = 5'h00;
	logic [31:0] bus_wdata = 32'h0, bus_rdata;
	int err_count = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	ecr_file ecr_file_i (.clk, .rst, .ce, .mc_cmd, .mc_arg, .arith_ovf, .opcode, .mc_priv, .mc_wr, .mc_waddr,
		.mc_wdata, .mc_raddr_a, .mc_raddr_b, .mc_rdata_a, .mc_rdata_b, .acc_a, .acc_b, .index_x, .prog_cnt,
		.oper_addr, .instr_byte, .cond_flags, .ovf, .word_len, .var_len, .op_len, .shift_out, .cmp_eq,
		.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq);
	ecr_seq_model ecr_seq_model_i (.clk, .rst, .ce, .mc_cmd, .ovf, .jump_taken);
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input ecr_pkg::ecr_cmd_t c, input logic [7:0] a);
		@(posedge clk);
		mc_cmd <= c;
		mc_arg <= a;
		@(posedge clk);
		mc_cmd <= ecr_pkg::ECR_CMD_NOP;
		#1;
	endtask
	task automatic mcw(input logic [3:0] a, input logic [7:0] d, input logic p);
		@(posedge clk);
		{mc_wr, mc_waddr, mc_wdata, mc_priv} <= {1'b1, a, d, p};
		@(posedge clk);
		mc_wr <= 1'b0;
		#1;
	endtask
	task automatic bw(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		{bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
		@(posedge clk);
		bus_wr <= 1'b0;
		#1;
	endtask
	task automatic br(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		{bus_rd, bus_addr} <= {1'b1, a};
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		`CHK("bus_rdata", e, bus_rdata)
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		br(5'h10, 32'h0);
		for (int i = 0; i < 12; i++)
			mcw(4'(i), 8'h30 + 8'(i), 1'b1);
		`CHK("acc_a", 16'h3534, acc_a)
		`CHK("acc_b", 16'h3736, acc_b)
		`CHK("index_x", 16'h3332, index_x)
		`CHK("oper_addr", 16'h3938, oper_addr)
		`CHK("flags", 8'h30, cond_flags)
		`CHK("instr", 8'h31, instr_byte)
		mcw(4'hb, 8'hff, 1'b1);
		`CHK("prog_cnt", 15'h7f3a, prog_cnt)
		mcw(4'ha, 8'hff, 1'b1);
		cyc(ecr_pkg::ECR_CMD_INC_P, 8'h00);
		`CHK("prog_cnt wrap", 15'h0, prog_cnt)
		$display("test map done");
		mcw(4'hc, 8'h5a, 1'b1);
		@(posedge clk);
		mc_raddr_a <= 4'hc;
		mc_raddr_b <= 4'h4;
		mcw(4'hc, 8'h11, 1'b0);
		`CHK("hidden read", 8'h00, mc_rdata_a)
		`CHK("visible read", 8'h34, mc_rdata_b)
		@(posedge clk);
		mc_priv <= 1'b1;
		#1;
		`CHK("micro read", 8'h5a, mc_rdata_a)
		br(5'h10, 32'h4);
		bw(5'h11, 32'h4);
		`CHK("irq set", 1'b1, irq)
		bw(5'h10, 32'h4);
		`CHK("irq clear", 1'b0, irq)
		br(5'h13, 32'h0);
		$display("test hidden done");
		cyc(ecr_pkg::ECR_CMD_SHL_A, 8'h01);
		`CHK("shl a", 16'h6a69, acc_a)
		cyc(ecr_pkg::ECR_CMD_SHR_AB, 8'h00);
		`CHK("shr ab", 32'h35349b9b, {acc_a, acc_b})
		cyc(ecr_pkg::ECR_CMD_SHR_B, 8'h01);
		`CHK("shr b", 32'h3534cdcd, {acc_a, acc_b})
		`CHK("shr b out", 1'b1, shift_out)
		cyc(ecr_pkg::ECR_CMD_SHL_AB, 8'h00);
		`CHK("shl ab", 32'h6a699b9a, {acc_a, acc_b})
		`CHK("shl ab out", 1'b0, shift_out)
		cyc(ecr_pkg::ECR_CMD_SHR_A, 8'h01);
		`CHK("shr a", 16'hb534, acc_a)
		cyc(ecr_pkg::ECR_CMD_SHL_B, 8'h01);
		`CHK("shl b", 16'h3735, acc_b)
		`CHK("shl b out", 1'b1, shift_out)
		cyc(ecr_pkg::ECR_CMD_INC_X, 8'h00);
		`CHK("inc x", 16'h3333, index_x)
		mcw(4'h2, 8'h34, 1'b1);
		mcw(4'h3, 8'hb5, 1'b1);
		cyc(ecr_pkg::ECR_CMD_CMP_XA, 8'h00);
		`CHK("cmp eq", 2'b10, {cmp_eq, ovf})
		cyc(ecr_pkg::ECR_CMD_INC_X, 8'h00);
		cyc(ecr_pkg::ECR_CMD_CMP_XA, 8'h00);
		`CHK("cmp ne", 2'b01, {cmp_eq, ovf})
		$display("test shift done");
		cyc(ecr_pkg::ECR_CMD_JMP_OVF, 8'h00);
		`CHK("jump taken", 2'b10, {jump_taken, ovf})
		cyc(ecr_pkg::ECR_CMD_SET_OVF, 8'h00);
		`CHK("set ovf", 1'b1, ovf)
		cyc(ecr_pkg::ECR_CMD_CLR_OVF, 8'h00);
		`CHK("clr ovf", 1'b0, ovf)
		@(posedge clk);
		arith_ovf <= 1'b1;
		mc_cmd <= ecr_pkg::ECR_CMD_CLR_OVF;
		@(posedge clk);
		arith_ovf <= 1'b0;
		mc_cmd <= ecr_pkg::ECR_CMD_NOP;
		#1;
		`CHK("set beats clear", 1'b1, ovf)
		cyc(ecr_pkg::ECR_CMD_JMP_OVF, 8'h00);
		cyc(ecr_pkg::ECR_CMD_JMP_OVF, 8'h00);
		`CHK("jump not taken", 1'b0, jump_taken)
		$display("test overflow done");
		bw(5'h11, 32'h2);
		for (int w = 0; w < 4; w++)
		begin
			cyc(ecr_pkg::ECR_CMD_LOAD_W, 8'(w));
			`CHK("word_len", 2'(w), word_len)
			`CHK("irq wlen", 1'b1, irq)
			@(posedge clk);
			opcode <= 8'h08;
			#1;
			`CHK("var_len", 1'b1, var_len)
			`CHK("op_len var", 3'(w + 1), op_len)
			@(posedge clk);
			opcode <= 8'h00;
			#1;
			`CHK("op_len fixed", 3'h2, op_len)
			br(5'h0f, 32'(w << 2));
			bw(5'h10, 32'h2);
		end
		`CHK("irq off", 1'b0, irq)
		br(5'h12, 32'h4b);
		$display("test length done");
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("reset acc", 16'h0000, acc_a)
		`CHK("reset word_len", 2'h0, word_len)
		`CHK("reset irq", 1'b0, irq)
		br(5'h10, 32'h0);
		@(posedge clk);
		ce <= 1'b0;
		mc_cmd <= ecr_pkg::ECR_CMD_INC_X;
		@(posedge clk);
		ce <= 1'b1;
		mc_cmd <= ecr_pkg::ECR_CMD_NOP;
		#1;
		`CHK("frozen x", 16'h0000, index_x)
		$display("test reset done");
		results();
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		err_count++;
		results();
	end
endmodule
